// file: msp_top.sv
// Melody score serial port, score FIFO, playback control and APB access
//
// Functional notes
// - Refill enabled and fill at or below threshold drives interrupt low outside digital sleep.
// - Empty FIFO during play keeps acting on the last word taken.
// - Standby with loaded FIFO plus run bit set enters play.
// - Clearing run bit while playing returns to stop.
// - Leaving digital sleep always resumes in stop.
// - Digital sleep freezes internal logic although the clock still runs.
// - Words written with run set and FIFO empty start within 20 us.
// - Stopping playback clears the FIFO word counter.
// - Serial data is sampled on each serial clock rising edge.
// - Index and control may arrive with a pause or unbroken 24 bits.
// - Control word may arrive as two bytes with any gap.
// - Frame strobe rising edge ends a frame; last 24 bits count.
// - A 16-bit frame is a score word for index 00h.
// - The score FIFO holds 32 words.
// - Entering digital sleep discards FIFO contents and clears the run bit, keeps other registers.
// - Refill threshold and refill enable live at index 34h.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "msp_map.svh"

module msp_top #(
    parameter int DEPTH    = `MSP_FIFO_DEPTH,
    parameter int NOTE_CYC = `MSP_NOTE_US * `MSP_CLK_MHZ
) (
    input  wire logic        CLK_I,              // System clock, 50 MHz
    input  wire logic        RSTN_I,             // Async reset, active low
    input  wire logic        PSEL_I,             // APB select
    input  wire logic        PENABLE_I,          // APB access phase
    input  wire logic        PWRITE_I,           // APB direction
    input  wire logic [11:0] PADDR_I,            // APB byte address
    input  wire logic [31:0] PWDATA_I,           // APB write data
    output logic      [31:0] PRDATA_O,           // APB read data
    output logic             PREADY_O,           // APB ready
    output logic             PSLVERR_O,          // APB error, unmapped
    input  wire logic        SER_CLK_I,          // Serial bit clock pin
    input  wire logic        SER_FRAME_I,        // Serial frame strobe pin
    input  wire logic        SERIAL_DATA_IN_I,   // Serial data pin
    output logic             IRQ_N_O,            // Refill request, low
    output logic      [15:0] SCORE_WORD_O,       // Word being played
    output logic             PLAYING_O,          // Play state
    output logic             SLEEPING_O          // Digital sleep state
);
    localparam int AW        = $clog2(DEPTH);
    localparam int START_CYC = `MSP_START_US * `MSP_CLK_MHZ;
    localparam logic [`MSP_IDX_W-1:0] IDX_SCORE = `MSP_IDX_SCORE;

    msp_fifo_if #(.W(`MSP_WORD_W), .AW(AW)) fif ();

    msp_score_fifo #(.DEPTH(DEPTH), .W(`MSP_WORD_W)) u_fifo (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .f      (fif)
    );

    // Register index decode, shared by read mux and error answer
    function automatic logic reg_known(input logic [`MSP_IDX_W-1:0] idx);
        return (idx == `MSP_IDX_SCORE) || (idx == `MSP_IDX_CTRL) ||
               (idx == `MSP_IDX_IRQ) || (idx == `MSP_IDX_PWR) ||
               (idx == `MSP_IDX_STAT);
    endfunction : reg_known

    // Pin synchronisers: [0] first stage, [1] second, [2] edge history
    logic [2:0] sclk_s;
    logic [2:0] sync_s;
    logic [1:0] serial_data_in_s;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sclk_s <= '0;
            sync_s <= '1;  // Strobe idles high; avoids a false edge
            serial_data_in_s <= '0;
        end else begin
            sclk_s <= {sclk_s[1:0], SER_CLK_I};
            sync_s <= {sync_s[1:0], SER_FRAME_I};
            serial_data_in_s <= {serial_data_in_s[0], SERIAL_DATA_IN_I};
        end
    end

    logic sclk_rise;
    logic sync_rise;
    assign sclk_rise = sclk_s[1] && !sclk_s[2];
    assign sync_rise = sync_s[1] && !sync_s[2];

    // Serial shifter; bits only accumulate, so byte gaps cost nothing
    logic [`MSP_FRAME_W-1:0] shift;
    logic [`MSP_FRAME_W-1:0] next_shift;
    logic [4:0]              bits;
    logic [4:0]              next_bits;

    always_comb begin
        next_shift = shift;
        next_bits  = bits;
        if (sync_rise) begin
            next_bits = '0;
        end else if (sclk_rise) begin
            next_shift = {shift[`MSP_FRAME_W-2:0], serial_data_in_s[1]};
            if (bits != `MSP_BITS_SAT) begin
                next_bits = bits + 5'h1;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            shift <= '0;
            bits  <= '0;
        end else begin
            shift <= next_shift;
            bits  <= next_bits;
        end
    end

    // Frame decode; a strobe edge wins over a coincident bit edge
    logic ser_full;
    logic ser_short;
    assign ser_full  = sync_rise && (bits >= `MSP_FRAME_BITS);
    assign ser_short = sync_rise && (bits == `MSP_SHORT_BITS);

    // Write sources: 0 is APB, 1 is the serial port and wins on conflict
    logic                  wr_v   [2];
    logic [`MSP_IDX_W-1:0] wr_idx [2];
    logic [15:0]           wr_dat [2];
    logic [`MSP_IDX_W-1:0] apb_idx;
    logic                  apb_ok;
    logic                  apb_wr;

    assign apb_idx   = PADDR_I[`MSP_ADDR_LSB +: `MSP_IDX_W];
    assign apb_ok    = reg_known(apb_idx) && (PADDR_I[1:0] == 2'h0) &&
                       (PADDR_I[11:10] == 2'h0);
    assign apb_wr    = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O &&
                       !PSLVERR_O;
    assign wr_v[0]   = apb_wr;
    assign wr_idx[0] = apb_idx;
    assign wr_dat[0] = PWDATA_I[15:0];
    assign wr_v[1]   = ser_full || ser_short;
    assign wr_idx[1] = ser_full ? shift[`MSP_WORD_W +: `MSP_IDX_W]
                                : IDX_SCORE;
    assign wr_dat[1] = shift[`MSP_WORD_W-1:0];

    // Control registers
    logic                       run;
    logic                       irq_en;
    logic                       dsleep;
    logic [`MSP_IRQ_THR_W-1:0]  thr;
    logic                       next_run;
    logic                       next_irq_en;
    logic                       next_dsleep;
    logic [`MSP_IRQ_THR_W-1:0]  next_thr;
    logic                       clr;
    logic                       push;
    msp_pkg::msp_word_t         push_data;

    // Registers other than power stay frozen while the section sleeps
    always_comb begin
        next_run    = run;
        next_irq_en = irq_en;
        next_dsleep = dsleep;
        next_thr    = thr;
        clr         = 1'h0;
        push        = 1'h0;
        push_data   = '0;
        for (int s = 0; s < 2; s++) begin
            if (wr_v[s]) begin
                case (wr_idx[s])
                    `MSP_IDX_SCORE: if (!dsleep) begin
                        push      = 1'h1;
                        push_data = wr_dat[s];
                    end
                    `MSP_IDX_CTRL: if (!dsleep) begin
                        next_run = wr_dat[s][`MSP_CTRL_RUN];
                        clr      = clr | wr_dat[s][`MSP_CTRL_CLR];
                    end
                    `MSP_IDX_IRQ: if (!dsleep) begin
                        next_thr    = wr_dat[s][`MSP_IRQ_THR_LO +:
                                                `MSP_IRQ_THR_W];
                        next_irq_en = wr_dat[s][`MSP_IRQ_EN];
                    end
                    `MSP_IDX_PWR: begin
                        next_dsleep = wr_dat[s][`MSP_PWR_DSLEEP];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (clr) begin
            next_run    = 1'h0;
            next_irq_en = 1'h0;
            next_thr    = `MSP_THR_RST;
        end
        if (next_dsleep && !dsleep) begin
            next_run = 1'h0;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            run    <= 1'h0;
            irq_en <= 1'h0;
            dsleep <= 1'h0;
            thr    <= `MSP_THR_RST;
        end else begin
            run    <= next_run;
            irq_en <= next_irq_en;
            dsleep <= next_dsleep;
            thr    <= next_thr;
        end
    end

    // Playback state machine
    msp_pkg::msp_state_t state;
    msp_pkg::msp_state_t next_state;
    logic                run_rise;
    logic                flush;

    assign run_rise = next_run && !run;

    always_comb begin
        next_state = state;
        flush      = clr;
        unique case (state)
            msp_pkg::MSP_STOP: begin
                if (next_dsleep) begin
                    next_state = msp_pkg::MSP_SLEEP;
                    flush      = 1'h1;
                end else if (run_rise) begin
                    next_state = msp_pkg::MSP_PLAY;
                end else if (fif.full) begin
                    next_state = msp_pkg::MSP_STANDBY;
                end
            end
            msp_pkg::MSP_STANDBY: begin
                if (next_dsleep) begin
                    next_state = msp_pkg::MSP_SLEEP;
                    flush      = 1'h1;
                end else if (run_rise) begin
                    next_state = msp_pkg::MSP_PLAY;
                end
            end
            msp_pkg::MSP_PLAY: begin
                // Sleep from play is a host fault; it still stops cleanly
                if (next_dsleep) begin
                    next_state = msp_pkg::MSP_SLEEP;
                    flush      = 1'h1;
                end else if (!next_run) begin
                    next_state = msp_pkg::MSP_STOP;
                    flush      = 1'h1;
                end
            end
            msp_pkg::MSP_SLEEP: begin
                if (!next_dsleep) begin
                    next_state = msp_pkg::MSP_STOP;
                end
            end
        endcase
        if (clr && (next_state != msp_pkg::MSP_SLEEP)) begin
            next_state = msp_pkg::MSP_STOP;
        end
    end

    // Sequencer: takes one word per note period; holds it when empty.
    // Sleep acts as a clock block: nothing here moves outside play.
    logic [15:0]        timer;
    logic [15:0]        next_timer;
    msp_pkg::msp_word_t word;
    msp_pkg::msp_word_t next_word;
    logic               pop;

    always_comb begin
        next_timer = timer;
        next_word  = word;
        pop        = 1'h0;
        if (state == msp_pkg::MSP_PLAY) begin
            if (timer != 16'h0) begin
                next_timer = timer - 16'h1;
            end else if (!fif.empty) begin
                pop        = 1'h1;
                next_word  = fif.rdata;
                next_timer = 16'(NOTE_CYC - 1);
            end
        end
        if (flush) begin
            next_timer = 16'h0;
        end
    end

    assign fif.push  = push;
    assign fif.wdata = push_data;
    assign fif.pop   = pop;
    assign fif.flush = flush;

    // Status word for the read mux
    logic [31:0] status;
    always_comb begin
        status = '0;
        status[`MSP_STAT_CNT_LO +: AW+1] = fif.count;
        status[`MSP_STAT_ST_LO +: 4]     = state;
        status[`MSP_STAT_IRQ]            = !IRQ_N_O;
    end

    // APB answers with no wait; data is fetched in the setup cycle
    logic [31:0] next_prdata;
    logic        next_slverr;
    logic        next_irq_n;

    always_comb begin
        next_prdata = PRDATA_O;
        next_slverr = PSLVERR_O;
        if (PSEL_I && !PENABLE_I) begin
            next_slverr = !apb_ok;
            next_prdata = '0;
            if (apb_ok && !PWRITE_I) begin
                case (apb_idx)
                    `MSP_IDX_CTRL: next_prdata[`MSP_CTRL_RUN] = run;
                    `MSP_IDX_IRQ: begin
                        next_prdata[`MSP_IRQ_THR_LO +: `MSP_IRQ_THR_W] = thr;
                        next_prdata[`MSP_IRQ_EN] = irq_en;
                    end
                    `MSP_IDX_PWR: next_prdata[`MSP_PWR_DSLEEP] = dsleep;
                    `MSP_IDX_STAT: next_prdata = status;
                    default: next_prdata = '0;
                endcase
            end
        end
        next_irq_n = !(irq_en && (thr >= fif.count) &&
                       (state != msp_pkg::MSP_SLEEP));
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state        <= msp_pkg::MSP_STOP;
            timer        <= '0;
            word         <= '0;
            PRDATA_O     <= '0;
            PREADY_O     <= 1'h0;
            PSLVERR_O    <= 1'h0;
            IRQ_N_O      <= 1'h1;
            SCORE_WORD_O <= '0;
            PLAYING_O    <= 1'h0;
            SLEEPING_O   <= 1'h0;
        end else begin
            state        <= next_state;
            timer        <= next_timer;
            word         <= next_word;
            PRDATA_O     <= next_prdata;
            PREADY_O     <= 1'h1;
            PSLVERR_O    <= next_slverr;
            IRQ_N_O      <= next_irq_n;
            SCORE_WORD_O <= next_word;
            PLAYING_O    <= (next_state == msp_pkg::MSP_PLAY);
            SLEEPING_O   <= (next_state == msp_pkg::MSP_SLEEP);
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    sequence empty_play_write;
        (state == msp_pkg::MSP_PLAY) && fif.empty && push && !flush;
    endsequence
    sequence word_taken;
        pop || (state != msp_pkg::MSP_PLAY);
    endsequence

    irq_level_a: assert property (
        (irq_en && (thr >= fif.count) &&
         (state != msp_pkg::MSP_SLEEP)) |=> !IRQ_N_O)
        else $error("refill request not raised");
    irq_release_a: assert property (
        (!irq_en || (thr < fif.count)) |=> IRQ_N_O)
        else $error("refill request not released");
    standby_run_a: assert property (
        (state == msp_pkg::MSP_STANDBY && run_rise && !next_dsleep &&
         !clr) |=> (state == msp_pkg::MSP_PLAY) && PLAYING_O)
        else $error("run bit did not start play");
    stop_flush_a: assert property (
        (state == msp_pkg::MSP_PLAY && !next_run && !next_dsleep)
        |=> (state == msp_pkg::MSP_STOP) && fif.empty)
        else $error("stop did not empty fifo");
    hold_word_a: assert property (
        (state == msp_pkg::MSP_PLAY && fif.empty) |=> $stable(SCORE_WORD_O))
        else $error("word changed while fifo empty");
    wake_stop_a: assert property (
        (state == msp_pkg::MSP_SLEEP && !next_dsleep)
        |=> (state == msp_pkg::MSP_STOP) && !run)
        else $error("wake did not land in stop");
    sleep_freeze_a: assert property (
        (state == msp_pkg::MSP_SLEEP)[*2] |-> fif.empty && !pop &&
        $stable(SCORE_WORD_O)) else $error("logic moved while asleep");
    fast_start_a: assert property (
        empty_play_write |-> ##[1:START_CYC] word_taken)
        else $error("score word not started in time");
    short_frame_a: assert property (
        (ser_short && !dsleep) |-> push && (push_data == shift[15:0]))
        else $error("short frame not pushed as score");
    sample_edge_a: assert property (
        (sclk_rise && !sync_rise) |=> shift[0] == $past(serial_data_in_s[1]))
        else $error("serial bit not sampled on edge");

endmodule : msp_top

// file: msp_map.svh
// Register indices, field positions, reset values and timing figures
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH

// Register indices; the APB byte address is four times the index
`define MSP_IDX_SCORE   8'h00
`define MSP_IDX_CTRL    8'h32
`define MSP_IDX_IRQ     8'h34
`define MSP_IDX_PWR     8'h38
`define MSP_IDX_STAT    8'h3a
`define MSP_IDX_W       8
`define MSP_ADDR_LSB    2

// Field positions
`define MSP_CTRL_RUN    0
`define MSP_CTRL_CLR    1
`define MSP_IRQ_THR_LO  0
`define MSP_IRQ_THR_W   6
`define MSP_IRQ_EN      7
`define MSP_PWR_DSLEEP  0
`define MSP_STAT_CNT_LO 0
`define MSP_STAT_ST_LO  8
`define MSP_STAT_IRQ    16

// Reset values
`define MSP_THR_RST     6'h10

// Score store and serial frame geometry
`define MSP_FIFO_DEPTH  32
`define MSP_WORD_W      16
`define MSP_FRAME_W     24
`define MSP_FRAME_BITS  5'h18
`define MSP_SHORT_BITS  5'h10
`define MSP_BITS_SAT    5'h19

// Timing: clock rate, start latency bound, time each score word is held
`define MSP_CLK_MHZ     50
`define MSP_START_US    20
`define MSP_NOTE_US     10

`endif

// file: msp_pkg.sv
// Shared types of the melody score serial port
package msp_pkg;

    // Playback state, one-hot
    typedef enum logic [3:0] {
        MSP_STOP    = 4'h1,
        MSP_STANDBY = 4'h2,
        MSP_PLAY    = 4'h4,
        MSP_SLEEP   = 4'h8
    } msp_state_t;

    typedef logic [15:0] msp_word_t;

endpackage : msp_pkg

// file: msp_fifo_if.sv
// Connection between the control logic and the score FIFO
`timescale 1ns/10ps

interface msp_fifo_if #(
    parameter int W  = 16,
    parameter int AW = 5
);
    logic          push;
    logic          pop;
    logic          flush;
    logic [W-1:0]  wdata;
    logic [W-1:0]  rdata;
    logic [AW:0]   count;
    logic          full;
    logic          empty;

    modport owner (output push, pop, flush, wdata,
                   input  rdata, count, full, empty);
    modport store (input  push, pop, flush, wdata,
                   output rdata, count, full, empty);
endinterface : msp_fifo_if

// file: msp_score_fifo.sv
// Score word FIFO with first-word fall-through and flush
`timescale 1ns/10ps
`include "msp_map.svh"

module msp_score_fifo #(
    parameter int DEPTH = `MSP_FIFO_DEPTH,
    parameter int W     = `MSP_WORD_W
) (
    input wire logic   clk_i,   // System clock
    input wire logic   rstn_i,  // Asynchronous reset, active low
    msp_fifo_if.store  f        // Push, pop and status
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0]   next_count;
    logic          do_push;
    logic          do_pop;

    // Overfull pushes are dropped; the host must never send them
    always_comb begin
        do_push     = f.push && (count != FULL_CNT) && !f.flush;
        do_pop      = f.pop && (count != '0) && !f.flush;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        if (f.flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = '0;
        end else begin
            if (do_push) begin
                next_wr_ptr = wr_ptr + 1'h1;
            end
            if (do_pop) begin
                next_rd_ptr = rd_ptr + 1'h1;
            end
        end
    end

    // Pointer and fill registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage needs no reset; unread slots are never shown
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= f.wdata;
        end
    end

    assign f.rdata = mem[rd_ptr];
    assign f.count = count;
    assign f.full  = (count == FULL_CNT);
    assign f.empty = (count == '0);

    count_bound_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        count <= FULL_CNT) else $error("fifo fill above depth");
    full_guard_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (f.full && f.push && !f.pop && !f.flush) |=> f.full)
        else $error("push into full fifo changed fill");
    flush_empty_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        f.flush |=> f.empty) else $error("flush did not empty fifo");

endmodule : msp_score_fifo

// file: msp_ser_host.sv
// Serial host model: bit clock, frame strobe and data
`timescale 1ns/10ps

module msp_ser_host (
    output logic ser_clk_o,    // Bit clock, still outside frames
    output logic ser_frame_o,  // Frame strobe, rise ends a frame
    output logic ser_data_o    // Serial data, MSB first
);
    // Idle levels until the first frame
    initial begin
        ser_clk_o   = 1'b0;
        ser_frame_o = 1'b1;
        ser_data_o  = 1'b0;
    end

    // Shift n bits MSB first; data moves only while the clock is low
    task automatic shift(input logic [23:0] v, input int n);
        // Pins move off the rising system clock edges, never as they are sampled
        #5 ser_frame_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            ser_data_o = v[i];
            #80 ser_clk_o = 1'b1;
            #80 ser_clk_o = 1'b0;
        end
        // Invalid data must not look like the last bit
        ser_data_o = ~ser_data_o;
    endtask : shift

    // Strobe rise kept well clear of any bit clock edge
    task automatic close();
        #200 ser_frame_o = 1'b1;
        #400;
    endtask : close
endmodule : msp_ser_host

// file: tb_melody_score_serial_port_fifo.sv
// Bench for the melody score serial port and score FIFO
`timescale 1ns/10ps
`include "msp_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    bad_count++; $display("FAIL %0t got %h exp %h", $time, g, e); end end

module tb_melody_score_serial_port_fifo;
    logic        clk, rstn, psel, pen, pwr, pready, perr, err;
    logic        sclk, sfrm, sdat, irq_n, play, slp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] word;
    int          bad_count = 0;
    int          samples_checked = 0;

    msp_top #(.NOTE_CYC(20)) u_dut (.CLK_I(clk), .RSTN_I(rstn),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(perr), .SER_CLK_I(sclk), .SER_FRAME_I(sfrm),
        .SERIAL_DATA_IN_I(sdat), .IRQ_N_O(irq_n), .SCORE_WORD_O(word),
        .PLAYING_O(play), .SLEEPING_O(slp));
    msp_ser_host u_host (.ser_clk_o(sclk), .ser_frame_o(sfrm),
        .ser_data_o(sdat));

    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // One APB transfer; request held until ready is seen high
    task automatic apb(input logic w, input logic [7:0] i,
                       input logic [15:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= {2'h0, i, 2'h0};
        pwdata <= {16'h0000, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd   = prdata;
        err  = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    // Reset values and an unmapped index
    task automatic t_reset();
        apb(1'b0, `MSP_IDX_STAT, 16'h0000);
        `CHK(rd[11:0], {msp_pkg::MSP_STOP, 8'h00})
        apb(1'b0, `MSP_IDX_IRQ, 16'h0000);
        `CHK(rd[7:0], 8'h10)
        apb(1'b0, 8'h3f, 16'h0000);
        `CHK(err, 1'b1)
        `CHK(irq_n, 1'b1)
    endtask : t_reset

    // Unbroken frame, byte frame with long gaps, short score frame
    task automatic t_serial();
        u_host.shift({`MSP_IDX_IRQ, 16'h0005}, 24);
        u_host.close();
        apb(1'b0, `MSP_IDX_IRQ, 16'h0000);
        `CHK(rd[7:0], 8'h05)
        u_host.shift({16'h0000, `MSP_IDX_IRQ}, 8);
        repeat (150) @(posedge clk);
        u_host.shift(24'h000000, 8);
        repeat (150) @(posedge clk);
        u_host.shift(24'h00008c, 8);
        u_host.close();
        apb(1'b0, `MSP_IDX_IRQ, 16'h0000);
        `CHK(rd[7:0], 8'h8c)
        // Overlong frame: only the last 24 bits before the strobe count
        u_host.shift(24'h0000ff, 8);
        u_host.shift({`MSP_IDX_IRQ, 16'h0083}, 24);
        u_host.close();
        apb(1'b0, `MSP_IDX_IRQ, 16'h0000);
        `CHK(rd[7:0], 8'h83)
        u_host.shift(24'h00abcd, 16);
        u_host.close();
        apb(1'b0, `MSP_IDX_STAT, 16'h0000);
        `CHK(rd[5:0], 6'h01)
        `CHK(irq_n, 1'b0)
        apb(1'b1, `MSP_IDX_CTRL, 16'h0002);
    endtask : t_serial

    // Fill, start, refill request, empty hold, late word, stop
    task automatic t_play();
        apb(1'b1, `MSP_IDX_IRQ, 16'h0090);
        // Never more words than free places
        for (int i = 0; i < 32; i++) apb(1'b1, 8'h00, 16'(16'h1000 + i));
        `CHK(irq_n, 1'b1)
        apb(1'b0, `MSP_IDX_STAT, 16'h0000);
        `CHK(rd[11:0], {msp_pkg::MSP_STANDBY, 8'h20})
        apb(1'b1, `MSP_IDX_CTRL, 16'h0001);
        repeat (2) @(negedge clk);
        `CHK(play, 1'b1)
        for (int n = 0; n < 1000 && irq_n !== 1'b0; n++) @(negedge clk);
        `CHK(irq_n, 1'b0)
        apb(1'b0, `MSP_IDX_STAT, 16'h0000);
        `CHK(rd[5:0], 6'h10)
        apb(1'b1, `MSP_IDX_IRQ, 16'h0010);
        repeat (2) @(negedge clk);
        `CHK(irq_n, 1'b1)
        repeat (800) @(negedge clk);
        `CHK(word, 16'h101f)
        apb(1'b1, `MSP_IDX_SCORE, 16'h2222);
        for (int n = 0; n < 1000 && word !== 16'h2222; n++) @(negedge clk);
        `CHK(word, 16'h2222)
        apb(1'b1, `MSP_IDX_SCORE, 16'h3333);
        apb(1'b1, `MSP_IDX_SCORE, 16'h4444);
        apb(1'b1, `MSP_IDX_CTRL, 16'h0000);
        apb(1'b0, `MSP_IDX_STAT, 16'h0000);
        `CHK(rd[11:0], {msp_pkg::MSP_STOP, 8'h00})
        `CHK(play, 1'b0)
    endtask : t_play

    // Sleep from loaded standby drops the FIFO but keeps registers
    task automatic t_sleep();
        apb(1'b1, `MSP_IDX_IRQ, 16'h0005);
        for (int i = 0; i < 32; i++) apb(1'b1, 8'h00, 16'h0001);
        // Sleep only from standby; levels are muted outside this block
        apb(1'b1, `MSP_IDX_PWR, 16'h0001);
        apb(1'b1, `MSP_IDX_IRQ, 16'h0007);
        apb(1'b0, `MSP_IDX_STAT, 16'h0000);
        `CHK(rd[11:0], {msp_pkg::MSP_SLEEP, 8'h00})
        `CHK(slp, 1'b1)
        apb(1'b1, `MSP_IDX_PWR, 16'h0000);
        repeat (64) @(posedge clk);
        apb(1'b0, `MSP_IDX_IRQ, 16'h0000);
        `CHK(rd[7:0], 8'h05)
        apb(1'b0, `MSP_IDX_STAT, 16'h0000);
        `CHK(rd[11:0], {msp_pkg::MSP_STOP, 8'h00})
    endtask : t_sleep

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // Reset for six cycles, then the scenarios in turn
    initial begin
        {rstn, psel, pen, pwr, paddr, pwdata} = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_serial();
        t_play();
        t_sleep();
        finish_test();
    end

    // Watchdog: the scenarios need well under this span
    initial begin
        #1000000;
        bad_count++;
        finish_test();
    end
endmodule : tb_melody_score_serial_port_fifo
